// [core/pfs_port_mux.sv]
// pin function selection for port 1 pins 2..7 and port 3 pins 3,4,5,7
// Function
// - p1_2 analog channel ten under conditions
// - p1_3 analog channel eleven under conditions
// - timer b output overrides p1_3
// - timer c channel c on p1_3
// - timer a input needs mode not 000/001, except lin master in 000
// - timer a pulse output on p1_7
// - lin master shares p1_5 receive/timer
// - lin slave adds interrupt 1 on p1_5
// - p1_6 external uart0 clock input
// - p1_6 drives internal uart0 clock
// - p1_6 comparator b1 reference input
// - p1_7 comparator b1 signal input
// - p3_3 comparator b3 signal input
// - p3_4 comparator b3 reference input
// - p3_3 chip select, optional open drain
// - p3_4 data open drain in standard mode
// - p3_5 serial clock open drain option
// - p3_5 uart2 clock open drain option
// - p1_4 uart0 transmit, optional open drain
// - p3 pins 4, 5, 7 group pull-up on inputs
// - p3_3 high drive option
// - pull-up only for input pins
`timescale 1ns/1ps
module pfs_port_mux (
	input wire logic ref_clk_in, // system clock, 200 MHz
	input wire logic rstn_in, // asynchronous active-low reset
	input wire logic clk_en_in, // freezes all state but the reset synchroniser while low
	input wire pfs_pkg::pfs_ctrl_t ctrl_in, // peripheral control bits, same clock
	input wire logic [pfs_pkg::PFS_NPIN-1:0] dir_in, // direction bits, 1 = output
	input wire logic [pfs_pkg::PFS_NPIN-1:0] latch_in, // port output latch
	input wire pfs_pkg::pfs_periph_t periph_in, // peripheral outputs
	input wire logic [pfs_pkg::PFS_NPIN-1:0] pin_in, // pad levels, asynchronous
	output logic [pfs_pkg::PFS_NPIN-1:0] pin_out, // pad output value
	output logic [pfs_pkg::PFS_NPIN-1:0] pin_oe_n_out, // low while driving
	output logic [pfs_pkg::PFS_NPIN-1:0] pullup_out, // pull-up enable
	output logic [pfs_pkg::PFS_NPIN-1:0] high_drive_out, // high drive enable
	output pfs_pkg::pfs_inputs_t periph_out // inputs to the peripherals
);
	import pfs_pkg::*;

	// ****************************************
	// reset and pin synchronisers
	// ****************************************
	logic rst_meta_r; // first reset stage
	logic rst_sync_n_r; // released reset used by the rest
	logic [PFS_NPIN-1:0] pin_meta_r; // first pad stage, read only by the second
	logic [PFS_NPIN-1:0] pin_sync_r; // synchronised pad levels

	// reset release through two flops so release is clean against the clock
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_meta_r <= 1'b0;
			rst_sync_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_n_r <= rst_meta_r;
		end
	end

	// pads are asynchronous, two flops before any decode
	always_ff @(posedge ref_clk_in or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			pin_meta_r <= '0;
			pin_sync_r <= '0;
		end else if (clk_en_in) begin
			pin_meta_r <= pin_in;
			pin_sync_r <= pin_meta_r;
		end
	end

	// ****************************************
	// helpers
	// ****************************************
	// timer a input accepted only outside the two output-type modes
	function automatic logic ta_input_mode(input logic [2:0] mode, input logic pulse_ctrl);
		ta_input_mode = !pulse_ctrl && (mode != PFS_TA_MODE_TIMER) && (mode != PFS_TA_MODE_PULSE);
	endfunction

	// timer a pulse output condition for a given route
	function automatic logic ta_pulse(input pfs_ctrl_t c, input logic [1:0] route);
		ta_pulse = (c.timer_a_route == route) && !c.timer_a_pulse_out_ctrl && (c.timer_a_mode == PFS_TA_MODE_PULSE);
	endfunction

	// ****************************************
	// combinational selection
	// ****************************************
	logic [PFS_NPIN-1:0] drv_nxt; // pin is driven
	logic [PFS_NPIN-1:0] val_nxt; // driven value
	logic [PFS_NPIN-1:0] od_nxt; // open drain: drive only low
	logic [PFS_NPIN-1:0] is_in_nxt; // pin acts as input
	logic [PFS_NPIN-1:0] pu_nxt;
	logic [PFS_NPIN-1:0] hd_nxt;
	pfs_inputs_t pin_fn_nxt;
	logic ta_p15; // timer a input routed to p1_5
	logic ta_p17; // timer a input routed to p1_7
	logic p13_tc; // timer c channel c owns p1_3

	always_comb begin
		// general port default for every pin
		drv_nxt = dir_in;
		val_nxt = latch_in;
		od_nxt = '0;
		pin_fn_nxt = '0;
		// p1_2: analog channel ten
		pin_fn_nxt.key_input2 = ctrl_in.key_input2_enable && !dir_in[PFS_P1_2] && pin_sync_r[PFS_P1_2];
		if (!dir_in[PFS_P1_2] && !ctrl_in.key_input2_enable && ctrl_in.adc_channel == PFS_ADC_CH_AN10 &&
			ctrl_in.adc_group_select == PFS_ADC_GRP_P1 && !ctrl_in.timer_c_route_b) begin
			pin_fn_nxt.adc_an10 = pin_sync_r[PFS_P1_2];
		end
		// p1_3: timer b output beats everything but key input 3
		p13_tc = (ctrl_in.timer_c_route_c == PFS_TC_ROUTE_P1) && !ctrl_in.timer_b_output;
		pin_fn_nxt.key_input3 = ctrl_in.key_input3_enable && !dir_in[PFS_P1_3] && pin_sync_r[PFS_P1_3];
		if (ctrl_in.timer_b_output) begin
			drv_nxt[PFS_P1_3] = 1'b1;
			val_nxt[PFS_P1_3] = periph_in.timer_b_output;
		end else if (p13_tc) begin
			// timer c owns the pin; direction bit 0 makes it a capture input
			val_nxt[PFS_P1_3] = periph_in.timer_c_channel_c;
			if (!dir_in[PFS_P1_3]) begin
				pin_fn_nxt.timer_c_channel_c = pin_sync_r[PFS_P1_3];
			end
		end else if (!dir_in[PFS_P1_3] && !ctrl_in.key_input3_enable &&
			ctrl_in.adc_channel == PFS_ADC_CH_AN11 && ctrl_in.adc_group_select == PFS_ADC_GRP_P1) begin
			pin_fn_nxt.adc_an11 = pin_sync_r[PFS_P1_3];
		end
		// p1_4: uart0 transmit selected by route alone
		if (ctrl_in.uart0_transmit_route) begin
			drv_nxt[PFS_P1_4] = 1'b1;
			val_nxt[PFS_P1_4] = periph_in.uart0_txd;
			od_nxt[PFS_P1_4] = ctrl_in.uart_channel_type;
		end
		// p1_5: receive, timer a and interrupt 1 may all listen at once
		ta_p15 = (ctrl_in.timer_a_route == PFS_TA_ROUTE_P15) &&
			ta_input_mode(ctrl_in.timer_a_mode, ctrl_in.timer_a_pulse_out_ctrl);
		ta_p17 = (ctrl_in.timer_a_route == PFS_TA_ROUTE_P17) &&
			ta_input_mode(ctrl_in.timer_a_mode, ctrl_in.timer_a_pulse_out_ctrl);
		if (!dir_in[PFS_P1_5]) begin
			if (ctrl_in.uart0_receive_route) begin
				pin_fn_nxt.uart0_rxd = pin_sync_r[PFS_P1_5];
			end
			// lin master: receive plus timer a in timer mode
			if (ctrl_in.uart0_receive_route && ctrl_in.timer_a_route == PFS_TA_ROUTE_P15 &&
				!ctrl_in.timer_a_pulse_out_ctrl && ctrl_in.timer_a_mode == PFS_TA_MODE_TIMER) begin
				pin_fn_nxt.timer_a_pin = pin_sync_r[PFS_P1_5];
			end else if (ta_p15) begin
				pin_fn_nxt.timer_a_pin = pin_sync_r[PFS_P1_5];
			end
			// interrupt 1 on pin 5, lin slave (mode 011) included
			if (ctrl_in.ext_int1_route == PFS_INT1_ROUTE_P15 && ctrl_in.ext_int1_enable &&
				!ctrl_in.int1_comparator_select) begin
				pin_fn_nxt.ext_int1 = pin_sync_r[PFS_P1_5];
			end
		end
		// p1_6: uart0 clock or comparator reference
		if (ctrl_in.uart0_clock_route) begin
			if (ctrl_in.serial_clock_direction) begin
				if (!dir_in[PFS_P1_6]) begin
					pin_fn_nxt.uart0_ext_clk = pin_sync_r[PFS_P1_6];
				end
			end else if (ctrl_in.serial_mode_select == PFS_SMD_SYNC) begin
				drv_nxt[PFS_P1_6] = 1'b1;
				val_nxt[PFS_P1_6] = periph_in.uart0_clk;
			end
		end else if (ctrl_in.int1_comparator_select && !dir_in[PFS_P1_6]) begin
			pin_fn_nxt.comp_b1_reference_in = pin_sync_r[PFS_P1_6];
		end
		// p1_7: timer a pulse, timer a input, interrupt 1 or comparator
		if (ta_pulse(ctrl_in, PFS_TA_ROUTE_P17)) begin
			drv_nxt[PFS_P1_7] = 1'b1;
			val_nxt[PFS_P1_7] = periph_in.timer_a_pin;
		end else if (!dir_in[PFS_P1_7]) begin
			if (ta_p17) begin
				pin_fn_nxt.timer_a_pin = pin_sync_r[PFS_P1_7];
			end
			if (ctrl_in.ext_int1_route == PFS_INT1_ROUTE_P17 && ctrl_in.ext_int1_enable &&
				!ctrl_in.int1_comparator_select) begin
				pin_fn_nxt.ext_int1 = pin_sync_r[PFS_P1_7];
			end
			if (ctrl_in.ext_int1_enable && ctrl_in.int1_comparator_select &&
				ctrl_in.timer_a_route != PFS_TA_ROUTE_P17) begin
				pin_fn_nxt.comp_b1_signal_in = pin_sync_r[PFS_P1_7];
			end
		end
		// p3_3: chip select, interrupt 3 or comparator
		if (ctrl_in.chip_select_field == PFS_CS_IN) begin
			pin_fn_nxt.ssu_cs = pin_sync_r[PFS_P3_3];
			drv_nxt[PFS_P3_3] = 1'b0;
		end else if (ctrl_in.chip_select_field != PFS_CS_OFF) begin
			drv_nxt[PFS_P3_3] = 1'b1;
			val_nxt[PFS_P3_3] = periph_in.ssu_cs;
			od_nxt[PFS_P3_3] = ctrl_in.chip_select_open_drain;
		end else if (!dir_in[PFS_P3_3] && ctrl_in.ext_int3_enable) begin
			if (ctrl_in.int3_comparator_select) begin
				if (ctrl_in.timer_c_clock_route != PFS_TC_CLK_P33) begin
					pin_fn_nxt.comp_b3_signal_in = pin_sync_r[PFS_P3_3];
				end
			end else begin
				pin_fn_nxt.ext_int3 = pin_sync_r[PFS_P3_3];
			end
		end
		// p3_4: serial data or comparator reference
		if (ctrl_in.ssu_busy_p34) begin
			drv_nxt[PFS_P3_4] = 1'b1;
			val_nxt[PFS_P3_4] = periph_in.ssu_data;
			od_nxt[PFS_P3_4] = ctrl_in.serial_data_open_drain && !ctrl_in.bidirectional_mode_bit;
		end else if (ctrl_in.int3_comparator_select && !dir_in[PFS_P3_4] &&
			ctrl_in.timer_c_route_c != PFS_TC_ROUTE_P3 && !ctrl_in.uart2_route_p34) begin
			pin_fn_nxt.comp_b3_reference_in = pin_sync_r[PFS_P3_4];
		end
		// p3_5: serial clock from the sync unit or uart2, both open-drain capable
		if (ctrl_in.serial_clock_open_drain || ctrl_in.uart2_clock_open_drain) begin
			if (dir_in[PFS_P3_5] || drv_nxt[PFS_P3_5]) begin
				val_nxt[PFS_P3_5] = periph_in.serial_clk;
			end
			od_nxt[PFS_P3_5] = ctrl_in.serial_clock_open_drain || ctrl_in.uart2_clock_open_drain;
		end
		// input flags and options
		is_in_nxt = ~drv_nxt;
		pu_nxt = '0;
		for (int i = PFS_P3_4; i < PFS_NPIN; i++) begin
			pu_nxt[i] = ctrl_in.pullup_group_p3_high && is_in_nxt[i] && !dir_in[i];
		end
		hd_nxt = '0;
		hd_nxt[PFS_P3_3] = ctrl_in.drive_strength_p3_3;
	end

	// ****************************************
	// registered pin outputs
	// ****************************************
	// outputs come from flops; one cycle later than the controls, which the pads tolerate
	always_ff @(posedge ref_clk_in or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			pin_out <= '0;
			pin_oe_n_out <= '1; // released: all pins input after reset
		end else if (clk_en_in) begin
			for (int i = 0; i < PFS_NPIN; i++) begin
				// open drain drives only the low level
				pin_out[i] <= val_nxt[i];
				pin_oe_n_out[i] <= !(drv_nxt[i] && !(od_nxt[i] && val_nxt[i]));
			end
		end
	end

	// pad options
	always_ff @(posedge ref_clk_in or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			pullup_out <= '0;
			high_drive_out <= '0;
		end else if (clk_en_in) begin
			pullup_out <= pu_nxt;
			high_drive_out <= hd_nxt;
		end
	end

	// inputs toward the peripherals
	always_ff @(posedge ref_clk_in or negedge rst_sync_n_r) begin
		if (!rst_sync_n_r) begin
			periph_out <= '0;
		end else if (clk_en_in) begin
			periph_out <= pin_fn_nxt;
		end
	end
endmodule

// [pkg/pfs_pkg.sv]
// package for the port function select mux: codes, field layouts and carriers
package pfs_pkg;
	// ****************************************
	// field codes
	// ****************************************
	localparam logic [2:0] PFS_ADC_CH_AN10 = 3'h2; // channel select for channel ten
	localparam logic [2:0] PFS_ADC_CH_AN11 = 3'h3; // channel select for channel eleven
	localparam logic [1:0] PFS_ADC_GRP_P1 = 2'h1; // group select for port 1 channels
	localparam logic [1:0] PFS_TC_ROUTE_P1 = 2'h1; // timer c route code for port 1
	localparam logic [1:0] PFS_TC_ROUTE_P3 = 2'h2; // timer c route code for port 3
	localparam logic [1:0] PFS_TA_ROUTE_P17 = 2'h1; // timer a route to port 1 pin 7
	localparam logic [1:0] PFS_TA_ROUTE_P15 = 2'h2; // timer a route to port 1 pin 5
	localparam logic [2:0] PFS_TA_MODE_TIMER = 3'h0; // timer a plain timer mode
	localparam logic [2:0] PFS_TA_MODE_PULSE = 3'h1; // timer a pulse output mode
	localparam logic [2:0] PFS_TA_MODE_MEAS = 3'h3; // timer a mode used by lin slave
	localparam logic [2:0] PFS_INT1_ROUTE_P15 = 3'h1; // interrupt 1 route to pin 5
	localparam logic [2:0] PFS_INT1_ROUTE_P17 = 3'h0; // interrupt 1 route to pin 7
	localparam logic [2:0] PFS_SMD_SYNC = 3'h1; // serial mode: clock synchronous
	localparam logic [1:0] PFS_CS_OFF = 2'h0; // chip select unused
	localparam logic [1:0] PFS_CS_IN = 2'h1; // chip select as input
	localparam logic [1:0] PFS_TC_CLK_P33 = 2'h2; // timer c clock route to port 3 pin 3
	// ****************************************
	// pin numbering inside a port vector
	// ****************************************
	localparam int PFS_P1_2 = 0;
	localparam int PFS_P1_3 = 1;
	localparam int PFS_P1_4 = 2;
	localparam int PFS_P1_5 = 3;
	localparam int PFS_P1_6 = 4;
	localparam int PFS_P1_7 = 5;
	localparam int PFS_P3_3 = 6;
	localparam int PFS_P3_4 = 7;
	localparam int PFS_P3_5 = 8;
	localparam int PFS_P3_7 = 9;
	localparam int PFS_NPIN = 10;
	// ****************************************
	// carriers
	// ****************************************
	// control bits gathered from the peripherals
	typedef struct packed {
		logic key_input2_enable;
		logic key_input3_enable;
		logic [2:0] adc_channel;
		logic [1:0] adc_group_select;
		logic timer_c_route_b;
		logic [1:0] timer_c_route_c;
		logic timer_b_output;
		logic [1:0] timer_a_route;
		logic timer_a_pulse_out_ctrl;
		logic [2:0] timer_a_mode;
		logic [2:0] ext_int1_route;
		logic ext_int1_enable;
		logic int1_comparator_select;
		logic ext_int3_enable;
		logic int3_comparator_select;
		logic uart0_receive_route;
		logic uart0_transmit_route;
		logic uart0_clock_route;
		logic serial_clock_direction;
		logic [2:0] serial_mode_select;
		logic uart_channel_type;
		logic [1:0] chip_select_field;
		logic chip_select_open_drain;
		logic serial_data_open_drain;
		logic bidirectional_mode_bit;
		logic serial_clock_open_drain;
		logic uart2_clock_open_drain;
		logic ssu_busy_p34;
		logic [1:0] timer_c_clock_route;
		logic uart2_route_p34;
		logic pullup_group_p3_high;
		logic drive_strength_p3_3;
	} pfs_ctrl_t;
	// peripheral output values toward the pins
	typedef struct packed {
		logic timer_b_output;
		logic timer_c_channel_c;
		logic timer_a_pin;
		logic uart0_txd;
		logic uart0_clk;
		logic ssu_cs;
		logic ssu_data;
		logic serial_clk;
	} pfs_periph_t;
	// inputs delivered to the peripherals
	typedef struct packed {
		logic adc_an10;
		logic adc_an11;
		logic key_input2;
		logic key_input3;
		logic timer_c_channel_c;
		logic timer_a_pin;
		logic uart0_rxd;
		logic ext_int1;
		logic uart0_ext_clk;
		logic comp_b1_reference_in;
		logic comp_b1_signal_in;
		logic comp_b3_signal_in;
		logic comp_b3_reference_in;
		logic ext_int3;
		logic ssu_cs;
	} pfs_inputs_t;
endpackage

// [tb/pfs_pad_model.sv]
// far side model: package pads with the outside world behind them
`timescale 1ns/1ps
module pfs_pad_model (
	input wire logic [9:0] pin_out_in, // value the mux drives
	input wire logic [9:0] oe_n_in, // low while the mux drives
	input wire logic [9:0] ext_in, // level the board forces
	output logic [9:0] pin_in_out // level seen at the pad
);
	// a driven pad reads back its own value; a released one shows the board level
	assign pin_in_out = (pin_out_in & ~oe_n_in) | (ext_in & oe_n_in);
endmodule

// [tb/pfs_port_mux_props.sv]
// concurrent checks on the ports of the port function select mux
`timescale 1ns/1ps
module pfs_port_mux_props (
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic clk_en_in,
	input wire pfs_pkg::pfs_ctrl_t ctrl_in,
	input wire logic [9:0] dir_in,
	input wire logic [9:0] latch_in,
	input wire pfs_pkg::pfs_periph_t periph_in,
	input wire logic [9:0] pin_in,
	input wire logic [9:0] pin_out,
	input wire logic [9:0] pin_oe_n_out,
	input wire logic [9:0] pullup_out,
	input wire logic [9:0] high_drive_out,
	input wire pfs_pkg::pfs_inputs_t periph_out
);
	import pfs_pkg::*;
	// enabled edges since release; the pad sync path needs several before checks are fair
	logic [2:0] run_r;
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			run_r <= 3'h0;
		end else if (!clk_en_in) begin
			run_r <= 3'h0; // a frozen cycle breaks the history that the past values rely on
		end else if (run_r != 3'h7) begin
			run_r <= run_r + 3'h1;
		end
	end
	wire ok = run_r == 3'h7;
	pfs_ctrl_t c; // short aliases
	pfs_periph_t p;
	assign c = ctrl_in;
	assign p = periph_in;
	wire an10 = !dir_in[0] && !c.key_input2_enable && c.adc_channel == PFS_ADC_CH_AN10
		&& c.adc_group_select == PFS_ADC_GRP_P1 && !c.timer_c_route_b;
	wire cb1s = c.ext_int1_enable && c.int1_comparator_select && !dir_in[5] && c.timer_a_route != PFS_TA_ROUTE_P17;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);
	property p_tbo; ok && $past(c.timer_b_output) |-> !pin_oe_n_out[1] && pin_out[1] == $past(p.timer_b_output); endproperty
	a_tbo: assert property (p_tbo) else $error("timer b pin wrong");
	property p_pulse; ok && $past(c.timer_a_route == PFS_TA_ROUTE_P17 && !c.timer_a_pulse_out_ctrl
		&& c.timer_a_mode == PFS_TA_MODE_PULSE) |-> !pin_oe_n_out[5] && pin_out[5] == $past(p.timer_a_pin); endproperty
	a_pulse: assert property (p_pulse) else $error("pulse pin wrong");
	property p_pull; ok |-> (pullup_out & $past(dir_in)) == 10'h0; endproperty
	a_pull: assert property (p_pull) else $error("output pulled up");
	property p_drive; ok |-> high_drive_out[6] == $past(c.drive_strength_p3_3); endproperty
	a_drive: assert property (p_drive) else $error("drive wrong");
	property p_txd; ok && $past(c.uart0_transmit_route) |-> pin_oe_n_out[2] == $past(c.uart_channel_type && p.uart0_txd);
	endproperty
	a_txd: assert property (p_txd) else $error("transmit pin wrong");
	property p_ck; ok && $past(c.uart0_clock_route && !c.serial_clock_direction && c.serial_mode_select == PFS_SMD_SYNC)
		|-> !pin_oe_n_out[4] && pin_out[4] == $past(p.uart0_clk); endproperty
	a_ck: assert property (p_ck) else $error("clock pin wrong");
	property p_an10; ok && $past(an10) && $past(an10, 2) && $past(an10, 3) |-> periph_out.adc_an10 == $past(pin_in[0], 3);
	endproperty
	a_an10: assert property (p_an10) else $error("analog ten wrong");
	property p_cb1s; cb1s [*3] ##1 ok |-> periph_out.comp_b1_signal_in == $past(pin_in[5], 3); endproperty
	a_cb1s: assert property (p_cb1s) else $error("comparator input wrong");
	c_tbo: cover property (ok && $past(c.timer_b_output));
	c_an10: cover property (ok && $past(an10));
	c_cb1s: cover property (ok && $past(cb1s));
endmodule
bind pfs_port_mux pfs_port_mux_props u_pfs_port_mux_props (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
	.clk_en_in(clk_en_in), .ctrl_in(ctrl_in), .dir_in(dir_in), .latch_in(latch_in), .periph_in(periph_in),
	.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n_out(pin_oe_n_out), .pullup_out(pullup_out),
	.high_drive_out(high_drive_out), .periph_out(periph_out));

// [tb/pfs_port_mux_tb.sv]
// self-checking bench for the port function select mux
`timescale 1ns/1ps
module pfs_port_mux_tb;
	import pfs_pkg::*;
	typedef struct {int due; int k; int i; logic x;} pfs_note_t; // k: 0 oe_n 1 out 2 pull 3 drive 4 periph
	localparam int AN10 = 14, AN11 = 13, TCC = 10, TAP = 9, RXD = 8, INT1 = 7, XCLK = 6;
	localparam int CB1R = 5, CB1S = 4, CB3S = 3, CB3R = 2, CS = 0;
	logic ref_clk_in = 0, rstn_in = 0, clk_en_in = 1;
	pfs_ctrl_t ct = '0;
	pfs_periph_t per = '0;
	logic [9:0] dir = '0, lat = '0, ext = '0, pin_in, pin_out, oe_n, pu, hd, d_old;
	logic [14:0] pv;
	pfs_note_t q[$], n;
	int cyc = 0, n_fail = 0, cmp_count = 0, m, j;
	pfs_port_mux u_pfs_port_mux (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .clk_en_in(clk_en_in), .ctrl_in(ct),
		.dir_in(dir), .latch_in(lat), .periph_in(per), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n_out(oe_n),
		.pullup_out(pu), .high_drive_out(hd), .periph_out(pv));
	pfs_pad_model u_pfs_pad_model (.pin_out_in(pin_out), .oe_n_in(oe_n), .ext_in(ext), .pin_in_out(pin_in));
	initial begin
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end
	always @(posedge ref_clk_in) cyc <= cyc + 1;
	task check(string s, logic seen, logic exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s exp %b seen %b", s, exp, seen);
		end
	endtask
	task conclude;
		if (q.size() != 0) n_fail++; // a note never reached means an output went unwatched
		if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// note an expectation; four edges cover the two-flop pad sync plus the output flop
	task e(int k, int i, logic x);
		q.push_back('{cyc + 4, k, i, x});
	endtask
	task go;
		repeat (4) @(negedge ref_clk_in);
	endtask
	task clr; // quiet controls, fresh random data
		ct = '0;
		dir = '0;
		per = pfs_periph_t'(8'($urandom));
		ext = 10'($urandom);
		lat = 10'($urandom);
	endtask
	// monitor: outputs are only read on the falling edge, well away from their updates
	always @(negedge ref_clk_in) begin
		while (q.size() > 0 && q[0].due <= cyc) begin
			n = q.pop_front();
			case (n.k)
				0: check("oe_n", oe_n[n.i], n.x);
				1: check("out", pin_out[n.i], n.x);
				2: check("pullup", pu[n.i], n.x);
				3: check("drive", hd[n.i], n.x);
				default: check("periph", pv[n.i], n.x);
			endcase
		end
	end
	initial begin
		#15000;
		n_fail++;
		conclude;
	end
	initial begin
		void'($urandom(32'hb379));
		repeat (6) @(negedge ref_clk_in);
		for (m = 0; m < 10; m++) begin
			e(0, m, 1);
			e(1, m, 0);
		end
		repeat (6) @(negedge ref_clk_in);
		rstn_in = 1;
		go;
		// analog channels, key input and timer overrides on port 1
		clr;
		ct.adc_channel = PFS_ADC_CH_AN10;
		ct.adc_group_select = PFS_ADC_GRP_P1;
		e(4, AN10, ext[0]);
		go;
		ct.key_input2_enable = 1;
		e(4, AN10, 0);
		e(4, 12, ext[0]);
		ct.adc_channel = PFS_ADC_CH_AN11;
		e(4, AN11, ext[1]);
		go;
		ct.timer_b_output = 1;
		dir[1] = 1'($urandom);
		e(0, 1, 0);
		e(1, 1, per.timer_b_output);
		e(4, AN11, 0);
		go;
		ct.timer_b_output = 0;
		dir[1] = 0;
		ct.timer_c_route_c = PFS_TC_ROUTE_P1;
		e(4, TCC, ext[1]);
		e(4, AN11, 0);
		go;
		// every timer a mode: pulse output in mode 1, input only from mode 2 up
		for (m = 0; m < 8; m++) begin
			clr;
			ct.timer_a_route = PFS_TA_ROUTE_P17;
			ct.timer_a_mode = 3'(m);
			if (m == 1) begin
				dir[5] = 1'($urandom);
				e(0, 5, 0);
				e(1, 5, per.timer_a_pin);
			end else e(4, TAP, m > 1 ? ext[5] : 1'b0);
			go;
		end
		// lin master then lin slave sharing p1_5
		clr;
		ct.uart0_receive_route = 1;
		ct.timer_a_route = PFS_TA_ROUTE_P15;
		e(4, RXD, ext[3]);
		e(4, TAP, ext[3]);
		go;
		ct.timer_a_mode = PFS_TA_MODE_MEAS;
		ct.ext_int1_route = PFS_INT1_ROUTE_P15;
		ct.ext_int1_enable = 1;
		e(4, RXD, ext[3]);
		e(4, TAP, ext[3]);
		e(4, INT1, ext[3]);
		go;
		// uart0 clock in and out, then comparator b1 on p1_6 and p1_7
		clr;
		ct.uart0_clock_route = 1;
		ct.serial_clock_direction = 1;
		e(4, XCLK, ext[4]);
		go;
		ct.serial_clock_direction = 0;
		ct.serial_mode_select = PFS_SMD_SYNC;
		dir[4] = 1'($urandom);
		e(0, 4, 0);
		e(1, 4, per.uart0_clk);
		go;
		ct.uart0_clock_route = 0;
		dir[4] = 0;
		ct.int1_comparator_select = 1;
		ct.ext_int1_enable = 1;
		e(4, CB1R, ext[4]);
		e(4, CB1S, ext[5]);
		go;
		ct.timer_a_route = PFS_TA_ROUTE_P17;
		e(4, CB1S, 0);
		go;
		// comparator b3, signal input blocked by the timer c clock route
		clr;
		ct.ext_int3_enable = 1;
		ct.int3_comparator_select = 1;
		e(4, CB3S, ext[6]);
		e(4, CB3R, ext[7]);
		go;
		ct.timer_c_clock_route = PFS_TC_CLK_P33;
		e(4, CB3S, 0);
		go;
		// plain interrupt 3 once the comparator lets go of the pin
		ct.int3_comparator_select = 0;
		e(4, 1, ext[6]);
		go;
		// chip select codes with and without open drain, plus drive strength
		for (m = 0; m < 8; m++) begin
			clr;
			ct.chip_select_field = 2'(m);
			ct.chip_select_open_drain = m[2];
			ct.drive_strength_p3_3 = 1'($urandom);
			e(3, 6, ct.drive_strength_p3_3);
			if (m % 4 == 1) e(4, CS, ext[6]);
			else if (m % 4 == 0) e(0, 6, 1);
			else begin
				e(0, 6, m[2] & per.ssu_cs);
				if (!(m[2] & per.ssu_cs)) e(1, 6, per.ssu_cs);
			end
			go;
		end
		// open drain data, serial clocks and uart0 transmit
		for (m = 0; m < 8; m++) begin
			clr;
			ct.ssu_busy_p34 = 1;
			ct.serial_data_open_drain = m[0];
			ct.bidirectional_mode_bit = m[2]; // bidirectional mode never opens the drain
			per.ssu_data = m[1];
			e(0, 7, m[0] & m[1] & !m[2]);
			dir[8] = 1;
			ct.serial_clock_open_drain = m[0];
			ct.uart2_clock_open_drain = m[1];
			per.serial_clk = m[2];
			e(0, 8, m[1:0] != 0 && m[2]);
			e(1, 8, m[1:0] != 0 ? m[2] : lat[8]);
			ct.uart0_transmit_route = 1;
			ct.uart_channel_type = m[0];
			per.uart0_txd = m[2];
			e(0, 2, m[0] & m[2]);
			if (!(m[0] & m[2])) e(1, 2, m[2]);
			go;
		end
		// random plain port use with group pull-up
		for (m = 0; m < 8; m++) begin
			clr;
			dir = 10'($urandom);
			ct.pullup_group_p3_high = 1'($urandom);
			for (j = 0; j < 10; j++) begin
				e(0, j, !dir[j]);
				if (dir[j]) e(1, j, lat[j]);
				e(2, j, j > 6 && ct.pullup_group_p3_high && !dir[j]);
			end
			go;
		end
		// reset in mid-run: every output falls back to its reset level at once
		@(negedge ref_clk_in);
		rstn_in = 0;
		for (j = 0; j < 10; j++) begin
			e(0, j, 1);
			e(1, j, 0);
			e(2, j, 0);
			e(3, j, 0);
		end
		go;
		rstn_in = 1;
		go;
		// a low clock enable freezes every output
		d_old = dir;
		clk_en_in = 0;
		dir = ~dir;
		for (j = 0; j < 10; j++) e(0, j, !d_old[j]);
		go;
		clk_en_in = 1;
		// once enabled again the outputs catch up with the inverted directions
		for (j = 0; j < 10; j++) e(0, j, d_old[j]);
		go;
		repeat (2) @(negedge ref_clk_in);
		conclude;
	end
endmodule
